// file: verilog/gpiox_pkg.sv
package gpiox_pkg;
    localparam int GPIOX_WIDTH = 8;
    localparam int GPIOX_ADDR_W = 4;
    // Word offsets (byte address = 4 x index)
    localparam logic [GPIOX_ADDR_W-1:0] GPIOX_OFS_DATA = 4'h0;
    localparam logic [GPIOX_ADDR_W-1:0] GPIOX_OFS_DIR = 4'h1;
    localparam logic [GPIOX_ADDR_W-1:0] GPIOX_OFS_OPT = 4'h2;
    localparam logic [GPIOX_ADDR_W-1:0] GPIOX_OFS_SENS = 4'h3;
    localparam logic [GPIOX_ADDR_W-1:0] GPIOX_OFS_PEND = 4'h4;
    localparam logic [GPIOX_ADDR_W-1:0] GPIOX_OFS_PIN = 4'h5;
    localparam logic [7:0] GPIOX_RST_DATA = 8'h00;
    localparam logic [7:0] GPIOX_RST_DIR = 8'h00;
    localparam logic [7:0] GPIOX_RST_OPT = 8'h00;
    // Sensitivity code per vector: 0 falling, 1 rising
    localparam logic [1:0] GPIOX_RST_SENS = 2'h0;
    localparam logic [31:0] GPIOX_UNMAPPED = 32'h0000_0000;
    typedef enum logic [1:0] {
        GPIOX_FLOAT_IN,
        GPIOX_PULLUP_INT_IN,
        GPIOX_OPEN_DRAIN_OUT,
        GPIOX_PUSH_PULL_OUT
    } gpiox_mode_e;
endpackage

// file: verilog/gpiox_edge_det.sv
`timescale 1ns/1ps
// One external interrupt vector: latch, edge detector, clears
module gpiox_edge_det (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_level,
    input wire logic i_rising,
    input wire logic i_sens_change,
    input wire logic i_fetch,
    output logic o_pending
);
    logic prev;
    logic event_hit;

    assign event_hit = i_rising ? (i_level & ~prev) : (~i_level & prev);

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            prev <= 1'b1;
        end else begin
            prev <= i_level;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_pending <= 1'b0;
        end else if (event_hit) begin
            o_pending <= 1'b1;
        end else if (i_sens_change || i_fetch) begin
            o_pending <= 1'b0;
        end
    end
endmodule // gpiox_edge_det

// file: verilog/gpiox_port.sv
// Operation
// - Up to eight pins, each individually input or output.
// - Bit x of data, direction and option registers controls pin x.
// - Direction 0 makes input; data read returns pin level.
// - Data writes in input mode update latch only, not the pin.
// - Input option bit selects floating or pull-up.
// - Option bit set on input enables interrupt; edge requests vector.
// - Edge polarity programmable per vector in sensitivity register.
// - Pins sharing a vector are ANDed; one low pin masks others.
// - Vector fetch clears that vector's request latch.
// - Changing a vector's sensitivity clears its pending request.
// - Disabled pin feeds one to detector; toggling option may spur.
// - Direction 1 makes output driven from latch; read returns latch.
// - Output option selects push-pull or open-drain; one floats in OD.
// - Peripheral output overrides pin settings; pin readable in data.
// - Input pin with alternate output reads alternate output state.
// - Output pin with alternate input feeds latch value to it.
// - Analog use needs floating input; mux routes selected pin.
// - Direction/option: 00 float, 01 pull-up int, 10 OD, 11 push-pull.
// - Interrupt reaches CPU only if configured and global mask clear.
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module gpiox_port
    import gpiox_pkg::*;
#(
    parameter int NUM_PINS = GPIOX_WIDTH,
    parameter int NUM_VEC = 2,
    parameter logic [7:0] VEC_OF_PIN_HI = 8'hF0
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [GPIOX_ADDR_W+1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [gpiox_pkg::GPIOX_WIDTH-1:0] i_pin,
    output logic [gpiox_pkg::GPIOX_WIDTH-1:0] o_pin,
    output logic [gpiox_pkg::GPIOX_WIDTH-1:0] o_pin_oe,
    output logic [gpiox_pkg::GPIOX_WIDTH-1:0] o_pull_up_en,
    input wire logic [gpiox_pkg::GPIOX_WIDTH-1:0] i_alt_out_en,
    input wire logic [gpiox_pkg::GPIOX_WIDTH-1:0] i_alt_out,
    output logic [gpiox_pkg::GPIOX_WIDTH-1:0] o_alt_in,
    input wire logic [2:0] i_analog_sel,
    output logic o_analog_level,
    input wire logic i_global_mask,
    input wire logic [1:0] i_vec_fetch,
    output logic [1:0] o_ext_irq
);
    import gpiox_pkg::*;

    if (NUM_PINS != GPIOX_WIDTH || NUM_VEC != 2) begin : g_bad_cfg
        $error("gpiox_port: unsupported pin or vector count");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] pin_data_latch;
    logic [7:0] pin_direction;
    logic [7:0] pin_option;
    logic [1:0] edge_sensitivity_control;
    logic [7:0] pin_sync1;
    logic [7:0] pin_sync2;
    logic [1:0] pending;
    logic [1:0] sens_change;
    logic [7:0] pin_view;
    logic [7:0] det_in;
    logic [1:0] vec_level;
    logic [GPIOX_ADDR_W-1:0] word;
    logic in_range;
    logic wr_data, wr_dir, wr_opt, wr_sens;
    logic ack;

    assign word = i_avs_address[GPIOX_ADDR_W+1:2];
    assign in_range = (i_avs_address[1:0] == 2'h0);
    // Single-cycle answer: waitrequest drops in the cycle after the request
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
    // Misaligned writes are ignored like unmapped ones
    assign wr_data = i_avs_write & ack & in_range & i_avs_byteenable[0] && word == GPIOX_OFS_DATA;
    assign wr_dir = i_avs_write & ack & in_range & i_avs_byteenable[0] && word == GPIOX_OFS_DIR;
    assign wr_opt = i_avs_write & ack & in_range & i_avs_byteenable[0] && word == GPIOX_OFS_OPT;
    assign wr_sens = i_avs_write & ack & in_range & i_avs_byteenable[0] && word == GPIOX_OFS_SENS;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (i_avs_read | i_avs_write) & ~ack;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pin_data_latch <= GPIOX_RST_DATA;
            pin_direction <= GPIOX_RST_DIR;
            pin_option <= GPIOX_RST_OPT;
        end else begin
            if (wr_data) begin
                pin_data_latch <= i_avs_writedata[7:0];
            end
            if (wr_dir) begin
                pin_direction <= i_avs_writedata[7:0];
            end
            if (wr_opt) begin
                pin_option <= i_avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            edge_sensitivity_control <= GPIOX_RST_SENS;
            sens_change <= 2'h0;
        end else begin
            sens_change <= 2'h0;
            if (wr_sens) begin
                edge_sensitivity_control <= i_avs_writedata[1:0];
                sens_change <= i_avs_writedata[1:0] ^ edge_sensitivity_control;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pin_sync1 <= 8'hFF;
            pin_sync2 <= 8'hFF;
        end else begin
            pin_sync1 <= i_pin;
            pin_sync2 <= pin_sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pin drive, readback and interrupt input
    genvar g;
    generate
        for (g = 0; g < GPIOX_WIDTH; g++) begin : g_pin
            gpiox_mode_e mode;
            assign mode = gpiox_mode_e'({pin_direction[g], pin_option[g]});
            always_comb begin
                if (i_alt_out_en[g]) begin
                    o_pin[g] = i_alt_out[g];
                    o_pin_oe[g] = 1'b1;
                end else if (mode == GPIOX_PUSH_PULL_OUT) begin
                    o_pin[g] = pin_data_latch[g];
                    o_pin_oe[g] = 1'b1;
                end else if (mode == GPIOX_OPEN_DRAIN_OUT) begin
                    o_pin[g] = 1'b0;
                    o_pin_oe[g] = ~pin_data_latch[g];
                end else begin
                    o_pin[g] = 1'b0;
                    o_pin_oe[g] = 1'b0;
                end
            end
            assign o_pull_up_en[g] = (mode == GPIOX_PULLUP_INT_IN) & ~i_alt_out_en[g];
            always_comb begin
                if (i_alt_out_en[g]) begin
                    pin_view[g] = i_alt_out[g];
                end else if (pin_direction[g]) begin
                    pin_view[g] = pin_data_latch[g];
                end else begin
                    pin_view[g] = pin_sync2[g];
                end
            end
            assign o_alt_in[g] = pin_direction[g] ? pin_data_latch[g] : pin_sync2[g];
            assign det_in[g] = (mode == GPIOX_PULLUP_INT_IN) ? pin_sync2[g] : 1'b1;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // External interrupt vectors
    assign vec_level[0] = &(det_in | VEC_OF_PIN_HI);
    assign vec_level[1] = &(det_in | ~VEC_OF_PIN_HI);

    generate
        for (g = 0; g < 2; g++) begin : g_vec
            gpiox_edge_det u_det (
                .i_mclk(i_mclk),
                .i_sys_rst(i_sys_rst),
                .i_level(vec_level[g]),
                .i_rising(edge_sensitivity_control[g]),
                .i_sens_change(sens_change[g]),
                .i_fetch(i_vec_fetch[g]),
                .o_pending(pending[g])
            );
            assign o_ext_irq[g] = pending[g] & ~i_global_mask;
        end
    endgenerate

    // Analog mux: selected pin's level to converter rail
    assign o_analog_level = pin_sync2[i_analog_sel];

    ////////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_avs_readdata <= GPIOX_UNMAPPED;
        end else if (i_avs_read & ~ack) begin
            if (!in_range) begin
                o_avs_readdata <= GPIOX_UNMAPPED;
            end else if (word == GPIOX_OFS_DATA) begin
                o_avs_readdata <= {24'h000000, pin_view};
            end else if (word == GPIOX_OFS_DIR) begin
                o_avs_readdata <= {24'h000000, pin_direction};
            end else if (word == GPIOX_OFS_OPT) begin
                o_avs_readdata <= {24'h000000, pin_option};
            end else if (word == GPIOX_OFS_SENS) begin
                o_avs_readdata <= {30'h0, edge_sensitivity_control};
            end else if (word == GPIOX_OFS_PEND) begin
                o_avs_readdata <= {30'h0, pending};
            end else if (word == GPIOX_OFS_PIN) begin
                o_avs_readdata <= {24'h000000, pin_sync2};
            end else begin
                o_avs_readdata <= GPIOX_UNMAPPED;
            end
        end
    end
endmodule // gpiox_port

// file: tb/gpiox_port_properties.sv
`timescale 1ns/1ps
module gpiox_props (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [7:0] i_pin,
    input wire logic [7:0] o_pin,
    input wire logic [7:0] o_pin_oe,
    input wire logic [7:0] o_pull_up_en,
    input wire logic [7:0] i_alt_out_en,
    input wire logic [7:0] i_alt_out,
    input wire logic [2:0] i_analog_sel,
    input wire logic o_analog_level,
    input wire logic i_global_mask,
    input wire logic [1:0] i_vec_fetch,
    input wire logic [1:0] o_ext_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence s_req; $rose(i_avs_read || i_avs_write); endsequence
    // Pads unchanged long enough for the synchroniser and detector to settle
    sequence s_quiet; $stable(i_pin) [*4]; endsequence
    property p_wait; s_req |-> o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
    property p_rd8; i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0; endproperty
    property p_alt_oe; (i_alt_out_en & ~o_pin_oe) == 8'h0; endproperty
    property p_alt_val; ((o_pin ^ i_alt_out) & i_alt_out_en) == 8'h0; endproperty
    property p_mask; i_global_mask |-> o_ext_irq == 2'h0; endproperty
    property p_fetch; s_quiet ##0 i_vec_fetch[0] |=> !o_ext_irq[0]; endproperty
    property p_ana; s_quiet |-> o_analog_level == i_pin[i_analog_sel]; endproperty
    property p_pull; (o_pull_up_en & o_pin_oe & ~i_alt_out_en) == 8'h0; endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    a_rd8: assert property (p_rd8) else $error("upper read bits set");
    a_alt_oe: assert property (p_alt_oe) else $error("alt pin not driven");
    a_alt_val: assert property (p_alt_val) else $error("alt value lost");
    a_mask: assert property (p_mask) else $error("irq while masked");
    a_fetch: assert property (p_fetch) else $error("fetch kept request");
    a_ana: assert property (p_ana) else $error("analog route wrong");
    a_pull: assert property (p_pull) else $error("pull-up on output");
endmodule // gpiox_props
bind gpiox_port gpiox_props u_props (.*);

// file: tb/gpiox_pad_model.sv
`timescale 1ns/1ps
module gpiox_pad_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_drv,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_pu,
    input wire logic [7:0] i_ext,
    input wire logic [7:0] i_ext_en,
    output logic [7:0] o_level
);
    logic [7:0] flt = 8'h00;
    // Undriven pins without pull-up wander every cycle
    always @(posedge i_mclk) flt <= ~flt;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (i_oe[k]) o_level[k] = i_drv[k];
            else if (i_ext_en[k]) o_level[k] = i_ext[k];
            else if (i_pu[k]) o_level[k] = 1'h1;
            else o_level[k] = flt[k];
        end
    end
endmodule // gpiox_pad_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import gpiox_pkg::*;
    logic i_mclk = 1'h0, i_sys_rst = 1'h1, i_avs_read = 1'h0, i_avs_write = 1'h0;
    logic i_global_mask = 1'h0, o_avs_waitrequest, o_analog_level;
    logic [5:0] i_avs_address = 6'h0;
    logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [7:0] i_pin, o_pin, o_pin_oe, o_pull_up_en, o_alt_in, ext_v = 8'h0, ext_en = 8'hFF;
    logic [7:0] i_alt_out_en = 8'h0, i_alt_out = 8'h0;
    logic [2:0] i_analog_sel = 3'h0;
    logic [1:0] i_vec_fetch = 2'h0, o_ext_irq;
    int miscompares = 0, total_checks = 0;
    always #20 i_mclk = ~i_mclk;
    gpiox_port dut (.*);
    gpiox_pad_model pad (.i_mclk(i_mclk), .i_drv(o_pin), .i_oe(o_pin_oe), .i_pu(o_pull_up_en),
        .i_ext(ext_v), .i_ext_en(ext_en), .o_level(i_pin));
    task automatic tk(input int k);
        repeat (k) @(posedge i_mclk);
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n = 0;
        i_avs_address <= {a, 2'h0};
        i_avs_writedata <= {24'h0, d};
        i_avs_write <= w;
        i_avs_read <= !w;
        do begin
            tk(1);
            n++;
        end while (o_avs_waitrequest !== 1'h0 && n < 20);
        q = o_avs_readdata;
        if (n == 20) miscompares++;
        i_avs_write <= 1'h0;
        i_avs_read <= 1'h0;
        tk(1);
    endtask
    task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e);
        acc(1'h0, a, 8'h0);
        chk(n, q, {24'h0, e});
    endtask
    task automatic t_reset;
        rd("dir", GPIOX_OFS_DIR, GPIOX_RST_DIR);
        rd("opt", GPIOX_OFS_OPT, GPIOX_RST_OPT);
        rd("hole", 4'hF, 8'h00);
        chk("oe", o_pin_oe, 8'h00);
        $display("test reset end");
    endtask
    task automatic t_io;
        ext_v <= 8'h3C;
        acc(1'h1, GPIOX_OFS_DATA, 8'h55);
        rd("pins", GPIOX_OFS_DATA, 8'h3C);
        for (int k = 0; k < 8; k++) begin
            i_analog_sel <= k[2:0];
            tk(1);
            chk("ana", o_analog_level, ext_v[k]);
        end
        ext_en <= 8'h00;
        acc(1'h1, GPIOX_OFS_DIR, 8'hFF);
        acc(1'h1, GPIOX_OFS_OPT, 8'h0F);
        chk("oe", o_pin_oe, 8'hAF);
        chk("lvl", o_pin & o_pin_oe, 8'h05);
        chk("altin", o_alt_in, 8'h55);
        rd("latch", GPIOX_OFS_DATA, 8'h55);
        acc(1'h1, GPIOX_OFS_DATA, 8'hAA);
        chk("oe2", o_pin_oe, 8'h5F);
        acc(1'h1, GPIOX_OFS_OPT, 8'h00);
        acc(1'h1, GPIOX_OFS_DIR, 8'h00);
        {ext_v, ext_en, i_alt_out_en, i_alt_out} <= {8'h00, 8'h7E, 8'h81, 8'h80};
        tk(3);
        chk("altoe", o_pin_oe, 8'h81);
        rd("alt", GPIOX_OFS_DATA, 8'h80);
        $display("test io end");
    endtask
    task automatic t_irq;
        {ext_v, ext_en, i_alt_out_en, i_global_mask} <= {8'hFF, 8'hFF, 8'h00, 1'h1};
        acc(1'h1, GPIOX_OFS_SENS, 8'h03);
        acc(1'h1, GPIOX_OFS_OPT, 8'hFF);
        acc(1'h1, GPIOX_OFS_SENS, 8'h00);
        chk("pu", o_pull_up_en, 8'hFF);
        i_global_mask <= 1'h0;
        ext_v <= 8'hFE;
        tk(6);
        chk("irq", o_ext_irq, 2'h1);
        rd("pend", GPIOX_OFS_PEND, 8'h01);
        i_vec_fetch <= 2'h1;
        tk(1);
        i_vec_fetch <= 2'h0;
        tk(1);
        chk("fetch", o_ext_irq, 2'h0);
        ext_v <= 8'hFC;
        tk(6);
        chk("and", o_ext_irq, 2'h0);
        {ext_v, i_global_mask} <= {8'hEC, 1'h1};
        tk(6);
        chk("mask", o_ext_irq, 2'h0);
        i_global_mask <= 1'h0;
        tk(1);
        chk("unmask", o_ext_irq, 2'h2);
        acc(1'h1, GPIOX_OFS_SENS, 8'h02);
        tk(1);
        chk("sens", o_ext_irq, 2'h0);
        ext_v <= 8'hFC;
        tk(6);
        chk("rise", o_ext_irq, 2'h2);
        i_global_mask <= 1'h1;
        acc(1'h1, GPIOX_OFS_SENS, 8'h00);
        acc(1'h1, GPIOX_OFS_OPT, 8'h00);
        acc(1'h1, GPIOX_OFS_SENS, 8'h03);
        i_global_mask <= 1'h0;
        rd("off", GPIOX_OFS_PEND, 8'h00);
        acc(1'h1, GPIOX_OFS_OPT, 8'hFF);
        acc(1'h1, GPIOX_OFS_OPT, 8'h00);
        rd("spur", GPIOX_OFS_PEND, 8'h01);
        $display("test irq end");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        tk(20);
        i_sys_rst <= 1'h0;
        tk(1);
        t_reset;
        t_io;
        t_irq;
        tally_and_finish;
    end
    initial begin
        #100000;
        miscompares++;
        tally_and_finish;
    end
endmodule // testbench
